// [rtl/flash_status_error_flags.sv]
`timescale 1ns/1ps
`include "flash_status_consts.svh"
module flash_status_error_flags (
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Command core
    input wire logic CMD_DONE,
    input wire logic ACC_ERR_EVT,
    input wire logic PROT_VIOL_EVT,
    input wire logic [1:0] STAT_SET,
    output logic CMD_LAUNCH,
    output logic SEQ_ALLOW,
    output logic CONTROLLER_BUSY,
    // Array read path
    input wire logic RD_VALID,
    input wire logic RD_DBL_FAULT,
    input wire logic RD_SGL_FAULT,
    input wire logic RD_BUSY_BLK,
    // Configuration out
    output flash_status_pkg::wait_sel_t WAIT_SEL,
    output logic WAIT_MAX,
    // Interrupt requests
    output logic CMD_IRQ,
    output logic ERR_IRQ
);
    import flash_status_pkg::*;

    // ==========================================================
    // Bus decode
    logic [3:0] idx;
    logic mapped;
    logic acc;
    logic wr;
    logic setup_rd;
    logic [7:0] wb;

    assign idx = PADDR[5:2];
    assign mapped = (PADDR[7:6] == 2'h0) && (PADDR[1:0] == 2'h0) &&
                    (idx >= `IDX_CFG) && (idx <= `IDX_ECC);
    assign acc = PSEL && PENABLE && CLK_EN;
    assign wr = acc && PWRITE && mapped && PSTRB[0];
    assign setup_rd = PSEL && !PENABLE && !PWRITE;
    assign wb = PWDATA[7:0];
    assign PREADY = PSEL && PENABLE && CLK_EN;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    function automatic logic hit(input logic [3:0] i, input logic [3:0] r);
        hit = (i == r);
    endfunction

    // ==========================================================
    // State
    cmd_state_t state_ff, nxt_state;
    logic access_error_flag_ff, nxt_access_error_flag;
    logic pviol_ff, nxt_pviol;
    logic [1:0] completion_status_ff, nxt_completion_status;
    logic double_fault_flag_ff, nxt_double_fault_flag;
    logic single_fault_flag_ff, nxt_single_fault_flag;
    logic df_evt_ff, nxt_df_evt;
    logic sf_evt_ff, nxt_sf_evt;
    logic cc_ie_ff, nxt_cc_ie;
    logic ign_sf_ff, nxt_ign_sf;
    wait_sel_t wait_ff, nxt_wait;
    logic force_df_ff, nxt_force_df;
    logic force_sf_ff, nxt_force_sf;
    logic sf_ie_ff, nxt_sf_ie;
    logic launch_ff, nxt_launch;
    logic [31:0] prdata_ff, nxt_prdata;
    logic idle;

    assign idle = (state_ff == CMD_IDLE);

    // ==========================================================
    // Command status
    always_comb begin
        nxt_state = state_ff;
        nxt_access_error_flag = access_error_flag_ff;
        nxt_pviol = pviol_ff;
        nxt_completion_status = completion_status_ff;
        nxt_launch = 1'b0;
        if (wr && hit(idx, `IDX_STAT)) begin
            if (wb[`ST_ACCESS_ERROR_FLAG]) begin
                nxt_access_error_flag = 1'b0;
            end
            if (wb[`ST_PVIOL]) begin
                nxt_pviol = 1'b0;
            end
            // Launch only from idle with both error flags clear
            if (wb[`ST_DONE] && idle && !access_error_flag_ff && !pviol_ff) begin
                nxt_state = CMD_RUN;
                nxt_launch = 1'b1;
                nxt_completion_status = `COMPLETION_STATUS_RST;
            end
        end
        unique case (state_ff)
            CMD_IDLE: begin
            end
            CMD_RUN: begin
                if (CMD_DONE || ACC_ERR_EVT || PROT_VIOL_EVT) begin
                    nxt_state = CMD_IDLE;
                end
            end
        endcase
        // Hardware sets win over software clears
        if (ACC_ERR_EVT) begin
            nxt_access_error_flag = 1'b1;
        end
        if (PROT_VIOL_EVT) begin
            nxt_pviol = 1'b1;
        end
        nxt_completion_status = nxt_completion_status | STAT_SET;
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_ff <= CMD_IDLE;
            access_error_flag_ff <= 1'b0;
            pviol_ff <= 1'b0;
            completion_status_ff <= `COMPLETION_STATUS_RST;
            launch_ff <= 1'b0;
        end else if (CLK_EN) begin
            state_ff <= nxt_state;
            access_error_flag_ff <= nxt_access_error_flag;
            pviol_ff <= nxt_pviol;
            completion_status_ff <= nxt_completion_status;
            launch_ff <= nxt_launch;
        end
    end

    assign CMD_LAUNCH = launch_ff;
    assign CONTROLLER_BUSY = !idle;
    assign SEQ_ALLOW = idle && !pviol_ff;

    // ==========================================================
    // ECC fault flags, one-cycle capture stage
    always_comb begin
        nxt_df_evt = RD_VALID && (RD_DBL_FAULT || RD_BUSY_BLK || force_df_ff);
        nxt_sf_evt = RD_VALID && !ign_sf_ff &&
                     (RD_SGL_FAULT || RD_BUSY_BLK || force_sf_ff);
        nxt_double_fault_flag = double_fault_flag_ff;
        nxt_single_fault_flag = single_fault_flag_ff;
        if (wr && hit(idx, `IDX_ECC)) begin
            if (wb[`ECC_DF]) begin
                nxt_double_fault_flag = 1'b0;
            end
            if (wb[`ECC_SF]) begin
                nxt_single_fault_flag = 1'b0;
            end
        end
        // Sticky: a fault while the flag is set adds nothing
        if (df_evt_ff) begin
            nxt_double_fault_flag = 1'b1;
        end
        if (sf_evt_ff) begin
            nxt_single_fault_flag = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            double_fault_flag_ff <= 1'b0;
            single_fault_flag_ff <= 1'b0;
            df_evt_ff <= 1'b0;
            sf_evt_ff <= 1'b0;
        end else if (CLK_EN) begin
            double_fault_flag_ff <= nxt_double_fault_flag;
            single_fault_flag_ff <= nxt_single_fault_flag;
            df_evt_ff <= nxt_df_evt;
            sf_evt_ff <= nxt_sf_evt;
        end
    end

    // ==========================================================
    // Configuration and enables
    always_comb begin
        nxt_cc_ie = cc_ie_ff;
        nxt_ign_sf = ign_sf_ff;
        nxt_wait = wait_ff;
        nxt_force_df = force_df_ff;
        nxt_force_sf = force_sf_ff;
        nxt_sf_ie = sf_ie_ff;
        if (wr && hit(idx, `IDX_CFG)) begin
            nxt_cc_ie = wb[`CFG_CC_IE];
            nxt_ign_sf = wb[`CFG_IGN_SF];
            nxt_force_df = wb[`CFG_FORCE_DF];
            nxt_force_sf = wb[`CFG_FORCE_SF];
            // Wait field frozen while a command runs
            if (idle) begin
                nxt_wait = wb[`CFG_WAIT_HI:`CFG_WAIT_LO];
            end
        end
        if (wr && hit(idx, `IDX_ERR_EN)) begin
            nxt_sf_ie = wb[`EN_SF_IE];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cc_ie_ff <= 1'b0;
            ign_sf_ff <= 1'b0;
            wait_ff <= `WAIT_RST;
            force_df_ff <= 1'b0;
            force_sf_ff <= 1'b0;
            sf_ie_ff <= 1'b0;
        end else if (CLK_EN) begin
            cc_ie_ff <= nxt_cc_ie;
            ign_sf_ff <= nxt_ign_sf;
            wait_ff <= nxt_wait;
            force_df_ff <= nxt_force_df;
            force_sf_ff <= nxt_force_sf;
            sf_ie_ff <= nxt_sf_ie;
        end
    end

    assign WAIT_SEL = wait_ff;
    // Reserved codes behave as the maximum setting
    assign WAIT_MAX = (wait_ff != `WAIT_NONE);
    assign CMD_IRQ = idle && cc_ie_ff;
    assign ERR_IRQ = single_fault_flag_ff && sf_ie_ff;

    // ==========================================================
    // Read data, captured in the setup cycle
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setup_rd) begin
            nxt_prdata = 32'h0;
            if (mapped) begin
                unique case (idx)
                    `IDX_CFG: begin
                        nxt_prdata[`CFG_CC_IE] = cc_ie_ff;
                        nxt_prdata[`CFG_IGN_SF] = ign_sf_ff;
                        nxt_prdata[`CFG_WAIT_HI:`CFG_WAIT_LO] = wait_ff;
                        nxt_prdata[`CFG_FORCE_DF] = force_df_ff;
                        nxt_prdata[`CFG_FORCE_SF] = force_sf_ff;
                    end
                    `IDX_ERR_EN: begin
                        nxt_prdata[`EN_SF_IE] = sf_ie_ff;
                    end
                    `IDX_STAT: begin
                        // Bit 2 and bit 6 stay zero
                        nxt_prdata[`ST_DONE] = idle;
                        nxt_prdata[`ST_ACCESS_ERROR_FLAG] = access_error_flag_ff;
                        nxt_prdata[`ST_PVIOL] = pviol_ff;
                        nxt_prdata[`ST_BUSY] = !idle;
                        nxt_prdata[1:0] = completion_status_ff;
                    end
                    `IDX_ECC: begin
                        nxt_prdata[`ECC_DF] = double_fault_flag_ff;
                        nxt_prdata[`ECC_SF] = single_fault_flag_ff;
                    end
                    default: begin
                        nxt_prdata = 32'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            prdata_ff <= 32'h0;
        end else if (CLK_EN) begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign PRDATA = prdata_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    logic stat_wr;
    assign stat_wr = wr && hit(idx, `IDX_STAT);

    launch_go_a: assert property (
        stat_wr && wb[`ST_DONE] && idle && !access_error_flag_ff && !pviol_ff
        |=> CONTROLLER_BUSY && CMD_LAUNCH && !CMD_IRQ)
        else $error("launch did not start a command");
    access_error_flag_block_a: assert property (
        stat_wr && access_error_flag_ff |=> !CMD_LAUNCH)
        else $error("launch taken during access error");
    pviol_block_a: assert property (
        pviol_ff |-> !SEQ_ALLOW ##1 !CMD_LAUNCH)
        else $error("start allowed during protection violation");
    access_error_flag_set_a: assert property (
        ACC_ERR_EVT && CLK_EN |=> access_error_flag_ff && !CONTROLLER_BUSY)
        else $error("access error not recorded");
    access_error_flag_clr_a: assert property (
        stat_wr && wb[`ST_ACCESS_ERROR_FLAG] && !ACC_ERR_EVT |=> !access_error_flag_ff)
        else $error("access error not cleared");
    pviol_keep_a: assert property (
        stat_wr && !wb[`ST_PVIOL] && pviol_ff |=> pviol_ff)
        else $error("protection flag lost on write of zero");
    dbl_delay_a: assert property (
        RD_VALID && RD_DBL_FAULT && CLK_EN ##1 CLK_EN |=> double_fault_flag_ff)
        else $error("double fault not stored a cycle later");
    sgl_ignore_a: assert property (
        !single_fault_flag_ff && ign_sf_ff && CLK_EN ##1 !single_fault_flag_ff && CLK_EN |=> !single_fault_flag_ff)
        else $error("single fault set while ignored");
    sgl_force_a: assert property (
        RD_VALID && force_sf_ff && !ign_sf_ff && CLK_EN ##1 CLK_EN |=> single_fault_flag_ff)
        else $error("forced single fault not reported");
    completion_status_clr_a: assert property (
        CLK_EN && nxt_launch && STAT_SET == 2'h0 |=> completion_status_ff == 2'h0)
        else $error("completion status not cleared on start");
    rsvd_read_a: assert property (
        setup_rd && mapped && hit(idx, `IDX_STAT) && CLK_EN |=> PRDATA[2] == 1'b0)
        else $error("reserved status bit read nonzero");
    err_irq_a: assert property (
        sf_evt_ff && sf_ie_ff && CLK_EN && !wr |=> ERR_IRQ)
        else $error("enabled single fault raised no interrupt");

    // Flag set and clear
    pviol_set_a: assert property (
        PROT_VIOL_EVT && CLK_EN |=> pviol_ff)
        else $error("protection violation not recorded");
    access_error_flag_keep_a: assert property (
        stat_wr && !wb[`ST_ACCESS_ERROR_FLAG] && access_error_flag_ff |=> access_error_flag_ff)
        else $error("access error lost on write of zero");
    busy_done_a: assert property (
        CONTROLLER_BUSY && CMD_DONE && CLK_EN |=> !CONTROLLER_BUSY)
        else $error("busy still set after command end");
    completion_status_set_a: assert property (
        CLK_EN && STAT_SET != 2'h0 |=> (completion_status_ff & $past(STAT_SET)) == $past(STAT_SET))
        else $error("completion status error not recorded");
    completion_status_ro_a: assert property (
        stat_wr && !nxt_launch && STAT_SET == 2'h0 |=> $stable(completion_status_ff))
        else $error("completion status changed by a write");
    dbl_clr_a: assert property (
        wr && hit(idx, `IDX_ECC) && wb[`ECC_DF] && !df_evt_ff |=> !double_fault_flag_ff)
        else $error("double fault flag not cleared");
    sgl_clr_a: assert property (
        wr && hit(idx, `IDX_ECC) && wb[`ECC_SF] && !sf_evt_ff |=> !single_fault_flag_ff)
        else $error("single fault flag not cleared");
    dbl_busy_a: assert property (
        RD_VALID && RD_BUSY_BLK && CLK_EN ##1 CLK_EN |=> double_fault_flag_ff)
        else $error("busy block read did not set double fault");
    sgl_busy_a: assert property (
        RD_VALID && RD_BUSY_BLK && !ign_sf_ff && CLK_EN ##1 CLK_EN |=> single_fault_flag_ff)
        else $error("busy block read did not set single fault");
    dbl_force_a: assert property (
        RD_VALID && force_df_ff && CLK_EN ##1 CLK_EN |=> double_fault_flag_ff)
        else $error("forced double fault not reported");

    // Interrupts, configuration and freeze
    cmd_irq_a: assert property (
        cc_ie_ff && CONTROLLER_BUSY && CMD_DONE && CLK_EN && !wr |=> CMD_IRQ)
        else $error("command interrupt missing after completion");
    err_irq_drop_a: assert property (
        ERR_IRQ && wr && hit(idx, `IDX_ECC) && wb[`ECC_SF] && !sf_evt_ff |=> !ERR_IRQ)
        else $error("error interrupt held after flag clear");
    wait_hold_a: assert property (
        !idle |=> $stable(WAIT_SEL))
        else $error("wait field changed while a command runs");
    freeze_hold_a: assert property (
        !CLK_EN |=> $stable(state_ff) && $stable(access_error_flag_ff) && $stable(double_fault_flag_ff) && $stable(PRDATA))
        else $error("state moved while clock enable low");
endmodule

// [rtl/flash_status_consts.svh]
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH
// Notes on behaviour
// - Single-fault flag with its enable set requests the error interrupt.
// - Writing 1 to complete bit 7 launches; it stays 0 until done, access error or protection violation.
// - Access error bit 5 sets on sequence violation or illegal command.
// - While access error is set, launch writes are ignored.
// - Access error clears on write of 1; writing 0 leaves it.
// - Protection violation bit 4 sets on program or erase of protected area.
// - Protection violation clears on write of 1; writing 0 does nothing.
// - While protection violation is set, no sequence start and no launch.
// - Busy bit 3 reads 1 while a command runs, 0 when idle.
// - Status bit 2 reads 0 and ignores writes.
// - Completion status bits 1:0 set on command or reset-sequence errors.
// - Completion status clears when a command starts.
// - Busy and completion status read-only; other unused bits read 0.
// - Double-fault bit 1 sets on double fault or invalid read of busy block.
// - Double-fault flag clears on write of 1; writing 0 leaves it.
// - Single-fault bit 0 sets on corrected fault or busy-block read, unless ignored.
// - Single-fault flag clears on write of 1; writing 0 leaves it.
// - A new fault is reported only when its flag is already clear.
// - Wait codes 01 and 10 read back as written but act as 00.
// - Complete flag with its enable set requests the command interrupt.
// - Force controls make every array read set the matching fault flag, the single-fault one only when not ignored.
// - Fault flags are stored one cycle after the array read.

// Register indices; byte address is four times the index
`define IDX_CFG 4'h4
`define IDX_ERR_EN 4'h5
`define IDX_STAT 4'h6
`define IDX_ECC 4'h7
// Field positions
`define CFG_CC_IE 7
`define CFG_IGN_SF 4
`define CFG_WAIT_HI 3
`define CFG_WAIT_LO 2
`define CFG_FORCE_DF 1
`define CFG_FORCE_SF 0
`define EN_SF_IE 0
`define ST_DONE 7
`define ST_ACCESS_ERROR_FLAG 5
`define ST_PVIOL 4
`define ST_BUSY 3
`define ECC_DF 1
`define ECC_SF 0
// Reset values and the WAIT_NONE code
`define WAIT_RST 2'h0
`define WAIT_NONE 2'h3
`define COMPLETION_STATUS_RST 2'h0
`endif

// [rtl/flash_status_pkg.sv]
package flash_status_pkg;
    typedef enum logic [1:0] {
        CMD_IDLE = 2'b01,
        CMD_RUN = 2'b10
    } cmd_state_t;
    typedef logic [1:0] wait_sel_t;
endpackage

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import flash_status_pkg::*;
    // ==========
    // Signals
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic cmd_done = 1'b0;
    logic acc_evt = 1'b0;
    logic prot_evt = 1'b0;
    logic [1:0] stat_set = 2'h0;
    logic rd_valid = 1'b0;
    logic rd_dbl = 1'b0;
    logic rd_sgl = 1'b0;
    logic rd_blk = 1'b0;
    logic cmd_launch, seq_allow, controller_busy, wait_max, cmd_irq, err_irq;
    wait_sel_t wait_sel;
    logic [31:0] rd_data;
    logic rd_err;
    int err_total = 0;
    int compares = 0;

    always #2.5 core_clk = ~core_clk;

    flash_status_error_flags flash_status_error_flags_inst (
        .CORE_CLK(core_clk), .RST(rst), .CLK_EN(clk_en),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CMD_DONE(cmd_done), .ACC_ERR_EVT(acc_evt), .PROT_VIOL_EVT(prot_evt), .STAT_SET(stat_set),
        .CMD_LAUNCH(cmd_launch), .SEQ_ALLOW(seq_allow), .CONTROLLER_BUSY(controller_busy),
        .RD_VALID(rd_valid), .RD_DBL_FAULT(rd_dbl), .RD_SGL_FAULT(rd_sgl), .RD_BUSY_BLK(rd_blk),
        .WAIT_SEL(wait_sel), .WAIT_MAX(wait_max), .CMD_IRQ(cmd_irq), .ERR_IRQ(err_irq)
    );

    // ==========
    // Shared tasks
    task automatic print_verdict();
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h0, data};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 8'h00);
        chk(rd_data, {24'h0, exp});
    endtask

    task automatic core_evt(input logic d, input logic a, input logic p, input logic [1:0] s);
        @(posedge core_clk);
        cmd_done <= d;
        acc_evt <= a;
        prot_evt <= p;
        stat_set <= s;
        @(posedge core_clk);
        cmd_done <= 1'b0;
        acc_evt <= 1'b0;
        prot_evt <= 1'b0;
        stat_set <= 2'h0;
    endtask

    task automatic rd_evt(input logic d, input logic s, input logic b);
        @(posedge core_clk);
        rd_valid <= 1'b1;
        rd_dbl <= d;
        rd_sgl <= s;
        rd_blk <= b;
        @(posedge core_clk);
        rd_valid <= 1'b0;
        rd_dbl <= 1'b0;
        rd_sgl <= 1'b0;
        rd_blk <= 1'b0;
    endtask

    // ==========
    // Scenarios
    task automatic t_reset();
        chk(controller_busy, 0);
        chk(seq_allow, 1);
        rchk(8'h18, 8'h80);
        rchk(8'h1c, 8'h00);
        rchk(8'h14, 8'h00);
        rchk(8'h10, 8'h00);
    endtask

    task automatic t_launch();
        apb(1'b1, 8'h18, 8'h84);
        #1 chk(cmd_launch, 1);
        chk(controller_busy, 1);
        rchk(8'h18, 8'h08);
        core_evt(1'b0, 1'b0, 1'b0, 2'h1);
        core_evt(1'b1, 1'b0, 1'b0, 2'h0);
        rchk(8'h18, 8'h81);
        apb(1'b1, 8'h18, 8'h80);
        rchk(8'h18, 8'h08);
        rd_evt(1'b0, 1'b0, 1'b1);
        rchk(8'h1c, 8'h03);
        apb(1'b1, 8'h1c, 8'h03);
        rchk(8'h1c, 8'h00);
        core_evt(1'b1, 1'b0, 1'b0, 2'h0);
        rchk(8'h18, 8'h80);
        apb(1'b1, 8'h18, 8'h0b);
        rchk(8'h18, 8'h80);
    endtask

    task automatic t_acc();
        core_evt(1'b0, 1'b1, 1'b0, 2'h0);
        rchk(8'h18, 8'ha0);
        apb(1'b1, 8'h18, 8'h80);
        #1 chk(cmd_launch, 0);
        rchk(8'h18, 8'ha0);
        apb(1'b1, 8'h18, 8'h00);
        rchk(8'h18, 8'ha0);
        apb(1'b1, 8'h18, 8'h20);
        rchk(8'h18, 8'h80);
    endtask

    task automatic t_viol();
        apb(1'b1, 8'h18, 8'h80);
        core_evt(1'b0, 1'b0, 1'b1, 2'h0);
        #1 chk(seq_allow, 0);
        rchk(8'h18, 8'h90);
        apb(1'b1, 8'h18, 8'h80);
        #1 chk(cmd_launch, 0);
        apb(1'b1, 8'h18, 8'h00);
        rchk(8'h18, 8'h90);
        apb(1'b1, 8'h18, 8'h10);
        rchk(8'h18, 8'h80);
        chk(seq_allow, 1);
    endtask

    task automatic t_ecc();
        rd_evt(1'b1, 1'b0, 1'b0);
        rchk(8'h1c, 8'h02);
        apb(1'b1, 8'h1c, 8'h00);
        rchk(8'h1c, 8'h02);
        apb(1'b1, 8'h1c, 8'h02);
        rchk(8'h1c, 8'h00);
        apb(1'b1, 8'h14, 8'h01);
        apb(1'b1, 8'h10, 8'h10);
        rd_evt(1'b0, 1'b1, 1'b0);
        rchk(8'h1c, 8'h00);
        apb(1'b1, 8'h10, 8'h00);
        rd_evt(1'b0, 1'b1, 1'b0);
        #1 chk(err_irq, 0);
        @(posedge core_clk);
        #1 chk(err_irq, 1);
        rchk(8'h1c, 8'h01);
        apb(1'b1, 8'h14, 8'h00);
        #1 chk(err_irq, 0);
        apb(1'b1, 8'h14, 8'h01);
        apb(1'b1, 8'h1c, 8'h01);
        #1 chk(err_irq, 0);
        apb(1'b1, 8'h10, 8'h03);
        rd_evt(1'b0, 1'b0, 1'b0);
        rchk(8'h1c, 8'h03);
        apb(1'b1, 8'h10, 8'h00);
        apb(1'b1, 8'h1c, 8'h03);
        rchk(8'h1c, 8'h00);
    endtask

    task automatic t_irq_cmd();
        apb(1'b1, 8'h10, 8'h80);
        #1 chk(cmd_irq, 1);
        apb(1'b1, 8'h18, 8'h80);
        #1 chk(cmd_irq, 0);
        core_evt(1'b1, 1'b0, 1'b0, 2'h0);
        #1 chk(cmd_irq, 1);
        apb(1'b1, 8'h10, 8'h00);
        #1 chk(cmd_irq, 0);
    endtask

    task automatic t_wait();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            apb(1'b1, 8'h10, {4'h0, c, 2'h0});
            rchk(8'h10, {4'h0, c, 2'h0});
            chk(wait_sel, c);
            chk(wait_max, c != 2'h3);
        end
        apb(1'b1, 8'h10, 8'h00);
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h20, 8'hff);
        chk(rd_err, 1);
        apb(1'b0, 8'h20, 8'h00);
        chk(rd_err, 1);
        chk(rd_data, 32'h0);
        apb(1'b1, 8'h14, 8'h01);
        pstrb <= 4'h0;
        apb(1'b1, 8'h14, 8'h00);
        pstrb <= 4'hf;
        rchk(8'h14, 8'h01);
        chk(rd_err, 0);
    endtask

    task automatic t_freeze();
        @(posedge core_clk);
        clk_en <= 1'b0;
        core_evt(1'b0, 1'b1, 1'b0, 2'h0);
        clk_en <= 1'b1;
        rchk(8'h18, 8'h80);
        chk(controller_busy, 0);
    endtask

    // ==========
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_launch();
        t_acc();
        t_viol();
        t_ecc();
        t_irq_cmd();
        t_wait();
        t_unmapped();
        t_freeze();
        print_verdict();
    end

    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule
